// ---- rtl/urfe_pkg.sv ----
package urfe_pkg;

    // register byte addresses, one aligned word each
    localparam logic [7:0] URFE_DATA_OFF = 8'h00;
    localparam logic [7:0] URFE_STAT_OFF = 8'h04;
    localparam logic [7:0] URFE_CTRL_OFF = 8'h08;
    localparam logic [7:0] URFE_BAUD_OFF = 8'h0c;
    localparam logic [7:0] URFE_PORT_OFF = 8'h10;
    localparam logic [7:0] URFE_DDIR_OFF = 8'h14;
    localparam logic [7:0] URFE_PIN_OFF = 8'h18;

    // status fields
    localparam int URFE_ST_RXC = 7;
    localparam int URFE_ST_FERR = 4;
    localparam int URFE_ST_OVR = 3;

    // control fields
    localparam int URFE_CT_RECEIVER_ENABLE_BIT = 4;
    localparam int URFE_CT_NINE = 2;
    localparam int URFE_CT_RX9 = 1;

    // values after reset
    localparam logic [7:0] URFE_BAUD_RST = 8'h00;
    localparam logic [7:0] URFE_DATA_RST = 8'h00;

    // oversampling figures
    localparam logic [3:0] URFE_SMP_FIRST = 4'h1;
    localparam logic [3:0] URFE_SMP_A = 4'h8;
    localparam logic [3:0] URFE_SMP_B = 4'h9;
    localparam logic [3:0] URFE_SMP_C = 4'ha;
    localparam logic [3:0] URFE_SMP_LAST = 4'hf;
    localparam logic [3:0] URFE_BITS_8 = 4'h7;
    localparam logic [3:0] URFE_BITS_9 = 4'h8;

    localparam logic [1:0] URFE_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        URFE_IDLE = 2'b00,
        URFE_START = 2'b01,
        URFE_DATA = 2'b10,
        URFE_STOP = 2'b11
    } urfe_state_t;

    // character as held for software
    typedef struct packed {
        logic ninth;
        logic ferr;
        logic [7:0] data;
    } urfe_char_t;

endpackage : urfe_pkg

// ---- rtl/urfe_top.sv ----
// Functional notes
// [R1] sample pin sixteen times per bit
// [R2] idle low sample starts validation, sample one
// [R3] samples 8-10 mostly high reject start
// [R4] data bit is majority of samples 8-10
// [R5] shift each bit in once decided
// [R6] stop mostly low sets framing error
// [R7] every character loads data, sets complete; on overrun the unread byte is kept instead
// [R8] data address: read receive, write transmit
// [R9] nine-bit mode copies ninth bit on load
// [R10] unread byte kept, overrun set on new
// [R11] overrun visible change only on data read
// [R12] disabled receiver leaves pin as port
// [R13] enabled receiver forces pin to input
// [R14] port output bit still drives pull-up
// [R15] software checks framing before data read
// [R16] software checks overrun after data read
// [R17] nine-bit select gives nine data bits
// [R18] 8-bit baud divisor sets sample tick
// [R19] default frame: start, 8 lsb-first, stop
// [R20] reading data clears complete flag
// [R21] synchronise pin; no search before stop
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module urfe_top
    import urfe_pkg::*;
#(
    parameter int BAUD_W = 8
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_pin_in,
    output logic rx_pin_out,
    output logic rx_pin_oe,
    output logic rx_pin_pullup,
    output logic [7:0] tx_data,
    output logic tx_load
);

    function automatic logic addr_is(input logic [31:0] a,
                                     input logic [7:0] off);
        addr_is = (a[7:2] == off[7:2]);
    endfunction : addr_is

    // bus state
    logic ap_take, dp_wr_reg, rd_data_evt, wr_evt;
    logic [31:0] dp_addr_reg;

    // software registers
    logic [BAUD_W-1:0] baud_reg;
    logic rx_en_reg, nine_reg, port_out_reg, port_dir_reg;
    logic [7:0] tx_data_reg;

    // receive state
    urfe_char_t held_reg;
    logic rxc_reg, ovr_pend_reg, ovr_vis_reg;
    logic sync1_reg, sync2_reg;
    logic [BAUD_W-1:0] div_reg;
    urfe_state_t state_reg;
    logic [3:0] smp_reg;
    logic [3:0] bit_reg;
    logic vote_a_reg, vote_b_reg;
    logic [8:0] shreg_reg;
    logic tick, maj, decide, complete, stop_ok;
    logic [7:0] byte_next;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // zero wait states, so hready is always high when a phase ends
    assign ap_take = hsel && hready && (htrans == URFE_HTRANS_NONSEQ);
    assign rd_data_evt = ap_take && !hwrite && addr_is(haddr, URFE_DATA_OFF);
    assign wr_evt = dp_wr_reg && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= 32'h00000000;
        end
        else
        begin
            dp_wr_reg <= ap_take && hwrite;
            if (ap_take)
                dp_addr_reg <= haddr;
        end
    end

    // read data registered at the address phase; side effects happen there
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (ap_take && !hwrite)
        begin
            hrdata <= 32'h00000000;
            if (addr_is(haddr, URFE_DATA_OFF))
                hrdata[7:0] <= held_reg.data; // [R8]
            else if (addr_is(haddr, URFE_STAT_OFF))
            begin
                hrdata[URFE_ST_RXC] <= rxc_reg;
                hrdata[URFE_ST_FERR] <= held_reg.ferr;
                hrdata[URFE_ST_OVR] <= ovr_vis_reg;
            end
            else if (addr_is(haddr, URFE_CTRL_OFF))
            begin
                hrdata[URFE_CT_RECEIVER_ENABLE_BIT] <= rx_en_reg;
                hrdata[URFE_CT_NINE] <= nine_reg;
                hrdata[URFE_CT_RX9] <= held_reg.ninth;
            end
            else if (addr_is(haddr, URFE_BAUD_OFF))
                hrdata[BAUD_W-1:0] <= baud_reg; // [R18]
            else if (addr_is(haddr, URFE_PORT_OFF))
                hrdata[0] <= port_out_reg;
            else if (addr_is(haddr, URFE_DDIR_OFF))
                hrdata[0] <= port_dir_reg;
            else if (addr_is(haddr, URFE_PIN_OFF))
                hrdata[0] <= sync2_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            baud_reg <= BAUD_W'(URFE_BAUD_RST);
            rx_en_reg <= 1'b0;
            nine_reg <= 1'b0;
            port_out_reg <= 1'b0;
            port_dir_reg <= 1'b0;
            tx_data_reg <= URFE_DATA_RST;
            tx_load <= 1'b0;
        end
        else
        begin
            tx_load <= 1'b0;
            if (wr_evt)
            begin
                if (addr_is(dp_addr_reg, URFE_DATA_OFF))
                begin
                    tx_data_reg <= hwdata[7:0]; // [R8]
                    tx_load <= 1'b1;
                end
                if (addr_is(dp_addr_reg, URFE_CTRL_OFF))
                begin
                    rx_en_reg <= hwdata[URFE_CT_RECEIVER_ENABLE_BIT];
                    nine_reg <= hwdata[URFE_CT_NINE]; // [R17]
                end
                if (addr_is(dp_addr_reg, URFE_BAUD_OFF))
                    baud_reg <= hwdata[BAUD_W-1:0]; // [R18]
                if (addr_is(dp_addr_reg, URFE_PORT_OFF))
                    port_out_reg <= hwdata[0];
                if (addr_is(dp_addr_reg, URFE_DDIR_OFF))
                    port_dir_reg <= hwdata[0];
            end
        end
    end

    assign tx_data = tx_data_reg;

    // pin sharing with the general port
    assign rx_pin_oe = !rx_en_reg && port_dir_reg; // [R12] [R13]
    assign rx_pin_out = port_out_reg;
    // pull-up only matters while the pin is an input
    assign rx_pin_pullup = port_out_reg && !rx_pin_oe; // [R14]

    a_pin_input: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_en_reg |-> !rx_pin_oe) // [R13]
        else $error("pin driven while receiver enabled");
    a_pullup_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_en_reg |-> (rx_pin_pullup == port_out_reg)) // [R14]
        else $error("pull-up not following port bit");

    // two flops; only the second is looked at
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end
        else
        begin
            sync1_reg <= rx_pin_in; // [R21]
            sync2_reg <= sync1_reg;
        end
    end

    // tick every baud_reg+1 clocks: sixteen ticks per bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_reg <= '0;
        else if (!rx_en_reg || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + 1'b1;
    end
    assign tick = rx_en_reg && (div_reg == baud_reg); // [R1] [R18]

    assign maj = (vote_a_reg && vote_b_reg) || (vote_a_reg && sync2_reg)
        || (vote_b_reg && sync2_reg); // [R4]
    assign decide = tick && (smp_reg == URFE_SMP_C);
    assign complete = decide && (state_reg == URFE_STOP);
    assign stop_ok = maj;
    // lsb first: an 8-bit frame leaves the byte in the upper bits
    assign byte_next = nine_reg ? shreg_reg[7:0] : shreg_reg[8:1]; // [R19]

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= URFE_IDLE;
            smp_reg <= 4'h0;
            bit_reg <= 4'h0;
            vote_a_reg <= 1'b1;
            vote_b_reg <= 1'b1;
            shreg_reg <= 9'h000;
        end
        else if (!rx_en_reg)
            state_reg <= URFE_IDLE; // [R12]
        else if (tick)
        begin
            smp_reg <= smp_reg + 4'h1; // [R1]
            if (smp_reg == URFE_SMP_A)
                vote_a_reg <= sync2_reg;
            if (smp_reg == URFE_SMP_B)
                vote_b_reg <= sync2_reg;
            case (state_reg)
                URFE_IDLE:
                begin
                    if (!sync2_reg)
                    begin
                        state_reg <= URFE_START; // [R2]
                        smp_reg <= URFE_SMP_FIRST + 4'h1;
                        bit_reg <= 4'h0;
                    end
                end
                URFE_START:
                begin
                    if (smp_reg == URFE_SMP_C && maj)
                        state_reg <= URFE_IDLE; // [R3]
                    else if (smp_reg == URFE_SMP_LAST)
                        state_reg <= URFE_DATA;
                end
                URFE_DATA:
                begin
                    if (smp_reg == URFE_SMP_C)
                        shreg_reg <= {maj, shreg_reg[8:1]}; // [R4] [R5]
                    if (smp_reg == URFE_SMP_LAST)
                    begin
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == (nine_reg ? URFE_BITS_9 : URFE_BITS_8))
                            state_reg <= URFE_STOP; // [R17] [R19]
                    end
                end
                URFE_STOP:
                begin
                    // edge search resumes only after stop sampling
                    if (smp_reg == URFE_SMP_C)
                        state_reg <= URFE_IDLE; // [R21]
                end
                default:
                    state_reg <= URFE_IDLE;
            endcase
        end
    end

    // smp_reg counts 1..16 within a bit (16 held as 0 after wrap)
    a_sample_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && tick && state_reg == URFE_DATA
        && smp_reg == URFE_SMP_LAST) |=> (smp_reg == 4'h0)) // [R1]
        else $error("sample count does not wrap at sixteen");
    a_idle_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && tick && state_reg == URFE_IDLE && !sync2_reg)
        |=> (state_reg == URFE_START && smp_reg == 4'h2)) // [R2]
        else $error("falling edge not taken as sample one");
    a_start_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && decide && state_reg == URFE_START && maj)
        |=> state_reg == URFE_IDLE) // [R3]
        else $error("noisy start bit not rejected");
    a_shift_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && decide && state_reg == URFE_DATA)
        |=> (shreg_reg[8] == $past(maj)
        && shreg_reg[7:0] == $past(shreg_reg[8:1]))) // [R4] [R5]
        else $error("data bit not shifted as majority");

    // character hand-over; a same-cycle read frees the register first
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            held_reg <= '0;
            rxc_reg <= 1'b0;
            ovr_pend_reg <= 1'b0;
        end
        else
        begin
            if (rd_data_evt)
            begin
                rxc_reg <= 1'b0; // [R20]
                ovr_pend_reg <= 1'b0;
            end
            if (complete)
            begin
                if (rxc_reg && !rd_data_evt)
                    ovr_pend_reg <= 1'b1; // [R10]
                else
                begin
                    held_reg.data <= byte_next; // [R7]
                    held_reg.ferr <= !stop_ok; // [R6] [R15]
                    if (nine_reg)
                        held_reg.ninth <= shreg_reg[8]; // [R9]
                    rxc_reg <= 1'b1; // [R7]
                end
            end
        end
    end

    // overrun is seen only through a data read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ovr_vis_reg <= 1'b0;
        else if (rd_data_evt)
            ovr_vis_reg <= ovr_pend_reg; // [R11]
    end

    a_frame_err: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && complete && (!rxc_reg || rd_data_evt) && !stop_ok)
        |=> held_reg.ferr) // [R6]
        else $error("bad stop bit did not flag framing error");
    a_rx_complete: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && complete && (!rxc_reg || rd_data_evt))
        |=> (rxc_reg && held_reg.data == $past(byte_next))) // [R7]
        else $error("character not moved to data register");
    a_ninth_copy: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && complete && nine_reg && (!rxc_reg || rd_data_evt))
        |=> held_reg.ninth == $past(shreg_reg[8])) // [R9]
        else $error("ninth bit not copied on load");
    a_overrun_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && complete && rxc_reg && !rd_data_evt)
        |=> ($stable(held_reg) && ovr_pend_reg)) // [R10]
        else $error("unread byte overwritten or overrun lost");
    a_ovr_visible: assert property (@(posedge hclk) disable iff (!hresetn)
        !rd_data_evt |=> $stable(ovr_vis_reg)) // [R11]
        else $error("overrun flag changed without data read");
    a_rxc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_data_evt && !complete) |=> !rxc_reg) // [R20]
        else $error("complete flag not cleared by data read");
    a_stop_done: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_en_reg && tick && state_reg == URFE_STOP
        && smp_reg != URFE_SMP_C) |=> state_reg == URFE_STOP) // [R21]
        else $error("left stop bit before sampling finished");

endmodule : urfe_top

// ---- dv/urfe_tx_model.sv ----
`timescale 1ns/10ps
module urfe_tx_model
#(
    parameter int BIT_CLKS = 32
)
(
    input wire logic hclk,
    output logic line
);
    // idles high by driving, as a transmitter does between frames
    initial line = 1'b1;

    task automatic put(input logic v, input int clks);
        line <= v;
        repeat (clks) @(posedge hclk);
    endtask : put

    // start low, lsb first, stop level chosen by the caller
    task automatic send(input logic [8:0] d, input int nbits,
        input logic stop);
        @(posedge hclk);
        put(1'b0, BIT_CLKS);
        for (int i = 0; i < nbits; i++)
        begin
            put(d[i], BIT_CLKS);
        end
        put(stop, BIT_CLKS);
        line <= 1'b1;
    endtask : send

    // low pulse well short of half a bit, so only noise
    task automatic spike(input int clks);
        @(posedge hclk);
        put(1'b0, clks);
        line <= 1'b1;
        repeat (3 * BIT_CLKS) @(posedge hclk);
    endtask : spike
endmodule : urfe_tx_model

// ---- dv/tb.sv ----
`timescale 1ns/10ps
module tb
    import urfe_pkg::*;
;
    localparam logic [31:0] S_RXC = 32'h1 << URFE_ST_RXC;
    localparam logic [31:0] S_FE = 32'h1 << URFE_ST_FERR;
    localparam logic [31:0] S_OV = 32'h1 << URFE_ST_OVR;
    localparam logic [31:0] C_EN = 32'h1 << URFE_CT_RECEIVER_ENABLE_BIT;
    localparam logic [31:0] C_NINE = 32'h1 << URFE_CT_NINE;
    localparam logic [31:0] C_RX9 = 32'h1 << URFE_CT_RX9;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic rx_pin_out, rx_pin_oe, rx_pin_pullup, tx_load, tx_line, rx_pin;
    logic [7:0] tx_data;
    int n_fail = 0;
    int check_count = 0;

    // the pin level: port drive wins only while the receiver is off
    assign rx_pin = rx_pin_oe ? rx_pin_out : tx_line;

    urfe_top #(.BAUD_W(8)) urfe_top_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_pin_in(rx_pin), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe),
        .rx_pin_pullup(rx_pin_pullup), .tx_data(tx_data),
        .tx_load(tx_load));

    // baud divisor 1 gives 16 * 2 clocks per bit
    urfe_tx_model #(.BIT_CLKS(32)) urfe_tx_model_inst (.hclk(hclk),
        .line(tx_line));

    initial hclk = 1'b0;
    always #10 hclk = ~hclk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wait_ready();
        int n;
        n = 0;
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        // a slave that never answers ends the run here
        if (n >= 50)
        begin
            chk("hreadyout", 32'h1, 32'h0);
            stop_test();
        end
    endtask : wait_ready

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= URFE_HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge hclk);
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        wait_ready();
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic rdc(input string name, input logic [7:0] a,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        chk(name, exp, rd);
    endtask : rdc

    task automatic t_reset();
        chk("oe", 32'h0, {31'h0, rx_pin_oe});
        chk("resp", 32'h0, {31'h0, hresp});
        rdc("status", URFE_STAT_OFF, 32'h0);
        rdc("baud", URFE_BAUD_OFF, {24'h0, URFE_BAUD_RST});
        rdc("data", URFE_DATA_OFF, {24'h0, URFE_DATA_RST});
        rdc("unmapped", 8'h1c, 32'h0);
    endtask : t_reset

    task automatic t_port();
        // port not driving, so the frame really reaches the disabled receiver
        urfe_tx_model_inst.send(9'h055, 8, 1'b1);
        rdc("status off", URFE_STAT_OFF, 32'h0);
        wr(URFE_DDIR_OFF, 32'h1);
        wr(URFE_PORT_OFF, 32'h1);
        #1;
        chk("oe off", 32'h1, {31'h0, rx_pin_oe});
        chk("pin out", 32'h1, {31'h0, rx_pin_out});
        chk("pullup driven", 32'h0, {31'h0, rx_pin_pullup});
        wr(URFE_CTRL_OFF, C_EN);
        #1;
        chk("oe on", 32'h0, {31'h0, rx_pin_oe});
        chk("pullup", 32'h1, {31'h0, rx_pin_pullup});
        wr(URFE_BAUD_OFF, 32'h1);
        rdc("baud", URFE_BAUD_OFF, 32'h1);
        rdc("pin", URFE_PIN_OFF, 32'h1);
    endtask : t_port

    task automatic t_char(input logic [7:0] d);
        urfe_tx_model_inst.send({1'b0, d}, 8, 1'b1);
        rdc("status", URFE_STAT_OFF, S_RXC);
        rdc("data", URFE_DATA_OFF, {24'h0, d});
        rdc("status read", URFE_STAT_OFF, 32'h0);
    endtask : t_char

    task automatic t_spike();
        urfe_tx_model_inst.spike(6);
        rdc("status spike", URFE_STAT_OFF, 32'h0);
        t_char(8'hc3);
    endtask : t_spike

    task automatic t_ferr();
        urfe_tx_model_inst.send(9'h03c, 8, 1'b0);
        rdc("status fe", URFE_STAT_OFF, S_RXC | S_FE);
        rdc("data fe", URFE_DATA_OFF, 32'h3c);
        t_char(8'h81);
    endtask : t_ferr

    task automatic t_nine();
        wr(URFE_CTRL_OFF, C_EN | C_NINE);
        urfe_tx_model_inst.send(9'h15a, 9, 1'b1);
        rdc("ctrl nine", URFE_CTRL_OFF, C_EN | C_NINE | C_RX9);
        rdc("data nine", URFE_DATA_OFF, 32'h5a);
        wr(URFE_CTRL_OFF, C_EN);
    endtask : t_nine

    task automatic t_ovr();
        urfe_tx_model_inst.send(9'h011, 8, 1'b1);
        urfe_tx_model_inst.send(9'h022, 8, 1'b1);
        rdc("status ovr", URFE_STAT_OFF, S_RXC);
        rdc("data ovr", URFE_DATA_OFF, 32'h11);
        rdc("status after", URFE_STAT_OFF, S_OV);
        rdc("data again", URFE_DATA_OFF, 32'h11);
        rdc("status clear", URFE_STAT_OFF, 32'h0);
    endtask : t_ovr

    task automatic t_txreg();
        wr(URFE_DATA_OFF, 32'h77);
        #1;
        chk("tx load", 32'h1, {31'h0, tx_load});
        chk("tx data", 32'h77, {24'h0, tx_data});
        // load strobe must last one cycle only
        @(posedge hclk);
        #1;
        chk("tx pulse", 32'h0, {31'h0, tx_load});
        rdc("rx side", URFE_DATA_OFF, 32'h11);
    endtask : t_txreg

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_port();
        t_char(8'ha5);
        t_spike();
        t_ferr();
        t_nine();
        t_ovr();
        t_txreg();
        stop_test();
    end

    // whole run is about 2800 clocks
    initial
    begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        stop_test();
    end
endmodule : tb
